// ---- src/fpm_pkg.sv ----
// constants and types shared by the frame preemption merge block
package fpm_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] REG_CTRL = 16'h02B0;
  localparam logic [15:0] REG_VERIFY = 16'h02B4;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_TXFC_LSB = 8;
  localparam int CTRL_RXFN_LSB = 12;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [31:0] VERIFY_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ==========================================================
  // line symbols
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_EXP = 8'h5D;
  // index 0 sits in the low byte
  localparam logic [3:0][7:0] SMD_SYM = {8'hB3, 8'h7F, 8'h4C, 8'hE6};
  localparam logic [3:0][7:0] FRAG_PRE = {8'h2A, 8'h9E, 8'h52, 8'h61};
  localparam logic [31:0] MCRC_XOR = 32'hFFFF_0000;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  // ==========================================================
  // byte counts
  localparam logic [15:0] PRE_LAST = 16'h0006;
  localparam logic [15:0] SEG_LAST = 16'h003B;
  localparam logic [15:0] MIN_REMAIN = 16'h0040;
  localparam logic [15:0] MIN_CUT_LEN = 16'h007C;
  localparam logic [15:0] FCS_LAST = 16'h0003;
  localparam logic [15:0] IFG_LAST = 16'h000B;
  localparam logic [3:0] RX_SFD_IDX = 4'h7;
  localparam logic [3:0] RX_DATA_IDX = 4'h8;
  localparam logic [2:0] RX_TAIL_FULL = 3'h4;
  // ==========================================================
  // states and kinds
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_DATA, TX_MCRC, TX_IFG} fpm_tx_st_t;
  typedef enum logic [1:0] {K_EXP, K_START, K_CONT, K_NONE} fpm_kind_t;
endpackage

// ---- src/fpm_crc32.sv ----
// byte-wide running ethernet crc with clear
`timescale 1ns/10ps
module fpm_crc32
  import fpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] fcs
);
  typedef struct packed {
    logic [31:0] crc;
  } fpm_crc_st_t;

  fpm_crc_st_t s_q;
  fpm_crc_st_t s_d;

  // ==========================================================
  // update
  always_comb begin
    logic [31:0] c;
    c = s_q.crc;
    s_d = s_q;
    if (clr) begin
      s_d.crc = CRC_INIT;
    end else if (en) begin
      c = c ^ {24'h00_0000, din};
      for (int i = 0; i < 8; i++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      s_d.crc = c;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign fcs = ~s_q.crc;
endmodule

// ---- src/fpm_top.sv ----
// preemption merge between mac and phy: tx fragmenting, rx classify, registers
// Functional notes
// - express frame: last preamble byte 0x55, start delimiter 0x5D
// - first part keeps 0x55, delimiter is frame count symbol, per frame
// - frame count wraps 0..3, symbols E6, 4C, 7F, B3
// - uninterrupted preemptable frame goes out unchanged, original crc included
// - on cut, run to next 60-byte boundary, append crc xor FFFF0000
// - cut only while 64 or more bytes remain, else finish normally
// - continuation last preamble byte: 61, 52, 9E, 2A by frame count
// - continuation delimiter is fragment count from 0, wrapping, same symbols
// - one frame may be cut repeatedly until all data is sent
// - frames under 124 bytes are never cut
// - only the lowest queue is preemptable; other traffic never cut
// - pending express frame interrupts running preemptable frame
// - receiver classifies by last preamble byte, delimiter and crc
// - unmapped register offset answers with decode error
`timescale 1ns/10ps
module fpm_top
  import fpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic exp_valid,
  input wire logic [7:0] exp_data,
  input wire logic exp_last,
  output logic exp_ready,
  input wire logic pre_valid,
  input wire logic [7:0] pre_data,
  input wire logic pre_last,
  input wire logic [15:0] pre_len,
  output logic pre_ready,
  output logic tx_en,
  output logic [7:0] txd,
  input wire logic rx_dv,
  input wire logic [7:0] rxd,
  output logic rx_sof,
  output logic [1:0] rx_kind,
  output logic [1:0] rx_frame_num,
  output logic rx_end,
  output logic rx_cut,
  output logic rx_discard,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [15:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef struct packed {
    fpm_tx_st_t tx_st;
    fpm_kind_t kind;
    logic src_pre;
    logic susp;
    logic [1:0] fcnt;
    logic [1:0] gcnt;
    logic [15:0] cnt;
    logic [15:0] seg;
    logic [15:0] done;
    logic [15:0] len;
    logic tx_en;
    logic [7:0] txd;
    logic [3:0] rx_cnt;
    logic [7:0] rx_lp;
    fpm_kind_t rx_kind;
    logic rx_active;
    logic [1:0] rx_fnum;
    logic [1:0] rx_efrag;
    logic [31:0] rx_tail;
    logic [2:0] rx_tcnt;
    logic rx_dv_q;
    logic rx_sof;
    logic rx_end;
    logic rx_cut;
    logic rx_discard;
    logic en;
    logic [31:0] verify;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } fpm_st_t;

  fpm_st_t s_q;
  fpm_st_t n;
  logic tx_crc_clr, tx_crc_en, rx_crc_clr, rx_crc_en, rx_xcrc_clr, rx_xcrc_en;
  logic [31:0] tx_fcs, rx_fcs, tx_mval, rx_xfcs, rx_chk;
  logic [15:0] tx_remain;
  logic tx_cut, wr_go, rd_go, wr_hit, rd_hit;
  logic [2:0] lp_idx, sfd_idx;
  logic rx_sfd_now, rx_exp_hit, rx_start_hit, rx_cont_hit, rx_seq_ok, rx_tail_ok;

  function automatic logic [2:0] fpm_find(input logic [7:0] b, input logic [3:0][7:0] tab);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (tab[i] == b) begin
        r = {1'b1, i[1:0]};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // crc engines
  fpm_crc32 u_tx_crc (
    .mclk(mclk), .rst_b(rst_b), .clr(tx_crc_clr), .en(tx_crc_en),
    .din(pre_data), .fcs(tx_fcs)
  );
  // rx crc lags by four bytes so the trailing crc is never folded in
  fpm_crc32 u_rx_crc (
    .mclk(mclk), .rst_b(rst_b), .clr(rx_crc_clr), .en(rx_crc_en),
    .din(s_q.rx_tail[7:0]), .fcs(rx_fcs)
  );
  // express frames get their own crc so an open reassembly survives them
  fpm_crc32 u_rx_xcrc (
    .mclk(mclk), .rst_b(rst_b), .clr(rx_xcrc_clr), .en(rx_xcrc_en),
    .din(s_q.rx_tail[7:0]), .fcs(rx_xfcs)
  );

  // ==========================================================
  // decode terms
  assign tx_mval = tx_fcs ^ MCRC_XOR;
  assign tx_remain = s_q.len - s_q.done - 16'h0001;
  // cut waits for the boundary byte; needs source still mid-frame
  assign tx_cut = s_q.tx_st == TX_DATA && s_q.src_pre && s_q.kind != K_EXP
    && exp_valid && s_q.seg == SEG_LAST && !pre_last
    && s_q.len >= MIN_CUT_LEN && tx_remain >= MIN_REMAIN;
  assign exp_ready = s_q.tx_st == TX_DATA && !s_q.src_pre;
  assign pre_ready = s_q.tx_st == TX_DATA && s_q.src_pre;
  assign lp_idx = fpm_find(s_q.rx_lp, FRAG_PRE);
  assign sfd_idx = fpm_find(rxd, SMD_SYM);
  assign rx_sfd_now = rx_dv && s_q.rx_cnt == RX_SFD_IDX;
  assign rx_exp_hit = s_q.rx_lp == PRE_BYTE && rxd == SFD_EXP;
  assign rx_start_hit = s_q.rx_lp == PRE_BYTE && sfd_idx[2];
  assign rx_cont_hit = lp_idx[2] && sfd_idx[2];
  assign rx_seq_ok = s_q.rx_active && lp_idx[1:0] == s_q.rx_fnum
    && sfd_idx[1:0] == s_q.rx_efrag;
  assign rx_tail_ok = s_q.rx_tcnt == RX_TAIL_FULL;
  assign rx_chk = (s_q.rx_kind == K_EXP) ? rx_xfcs : rx_fcs;
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && !s_q.rvalid;
  assign wr_hit = s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_VERIFY;
  assign rd_hit = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_VERIFY;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // ==========================================================
  // next state
  always_comb begin
    logic [31:0] rd_v;
    rd_v = 32'h0000_0000;
    n = s_q;
    tx_crc_clr = 1'b0;
    tx_crc_en = 1'b0;
    rx_crc_clr = 1'b0;
    rx_crc_en = 1'b0;
    rx_xcrc_clr = 1'b0;
    rx_xcrc_en = 1'b0;
    n.tx_en = 1'b0;
    n.txd = 8'h00;
    unique case (s_q.tx_st)
      TX_IDLE: begin
        // express always wins the idle slot
        if (exp_valid) begin
          n.src_pre = 1'b0;
          n.kind = K_EXP;
        end else if (pre_valid) begin
          n.src_pre = 1'b1;
          if (s_q.susp) begin
            n.kind = K_CONT;
          end else begin
            n.kind = s_q.en ? K_START : K_EXP;
            n.len = pre_len;
            n.done = 16'h0000;
            n.gcnt = 2'h0;
            tx_crc_clr = 1'b1;
          end
        end
        if (exp_valid || pre_valid) begin
          n.tx_st = TX_PRE;
          n.tx_en = 1'b1;
          n.txd = PRE_BYTE;
          n.cnt = 16'h0001;
          n.seg = 16'h0000;
        end
      end
      TX_PRE: begin
        n.tx_en = 1'b1;
        n.cnt = s_q.cnt + 16'h0001;
        n.txd = PRE_BYTE;
        if (s_q.cnt == PRE_LAST) begin
          n.tx_st = TX_SFD;
          if (s_q.kind == K_CONT) begin
            n.txd = FRAG_PRE[s_q.fcnt];
          end
        end
      end
      TX_SFD: begin
        n.tx_en = 1'b1;
        n.tx_st = TX_DATA;
        if (s_q.kind == K_EXP) begin
          n.txd = SFD_EXP;
        end else if (s_q.kind == K_START) begin
          n.txd = SMD_SYM[s_q.fcnt];
        end else begin
          n.txd = SMD_SYM[s_q.gcnt];
          n.gcnt = s_q.gcnt + 2'h1;
        end
      end
      TX_DATA: begin
        n.tx_en = 1'b1;
        if (!s_q.src_pre) begin
          n.txd = exp_data;
          if (exp_last) begin
            n.tx_st = TX_IFG;
            n.cnt = 16'h0000;
          end
        end else begin
          n.txd = pre_data;
          tx_crc_en = 1'b1;
          n.done = s_q.done + 16'h0001;
          n.seg = (s_q.seg == SEG_LAST) ? 16'h0000 : s_q.seg + 16'h0001;
          if (pre_last) begin
            n.tx_st = TX_IFG;
            n.cnt = 16'h0000;
            n.susp = 1'b0;
            n.gcnt = 2'h0;
            if (s_q.kind != K_EXP) begin
              n.fcnt = s_q.fcnt + 2'h1;
            end
          end else if (tx_cut) begin
            n.tx_st = TX_MCRC;
            n.cnt = 16'h0000;
            n.susp = 1'b1;
          end
        end
      end
      TX_MCRC: begin
        n.tx_en = 1'b1;
        n.txd = tx_mval[{s_q.cnt[1:0], 3'h0} +: 8];
        n.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == FCS_LAST) begin
          n.tx_st = TX_IFG;
          n.cnt = 16'h0000;
        end
      end
      TX_IFG: begin
        n.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == IFG_LAST) begin
          n.tx_st = TX_IDLE;
        end
      end
    endcase
    // receive side
    n.rx_sof = 1'b0;
    n.rx_end = 1'b0;
    n.rx_cut = 1'b0;
    n.rx_discard = 1'b0;
    n.rx_dv_q = rx_dv;
    if (rx_dv) begin
      if (s_q.rx_cnt < RX_SFD_IDX) begin
        n.rx_lp = rxd;
        n.rx_cnt = s_q.rx_cnt + 4'h1;
      end else if (rx_sfd_now) begin
        n.rx_cnt = RX_DATA_IDX;
        n.rx_sof = 1'b1;
        n.rx_tcnt = 3'h0;
        if (rx_exp_hit) begin
          n.rx_kind = K_EXP;
          rx_xcrc_clr = 1'b1;
        end else if (rx_start_hit) begin
          n.rx_kind = K_START;
          n.rx_fnum = sfd_idx[1:0];
          n.rx_efrag = 2'h0;
          n.rx_active = 1'b1;
          n.rx_discard = s_q.rx_active;
          rx_crc_clr = 1'b1;
        end else if (rx_cont_hit) begin
          n.rx_kind = K_CONT;
          if (rx_seq_ok) begin
            n.rx_efrag = s_q.rx_efrag + 2'h1;
          end else begin
            n.rx_discard = 1'b1;
            n.rx_active = 1'b0;
          end
        end else begin
          n.rx_kind = K_NONE;
        end
      end else begin
        n.rx_tail = {rxd, s_q.rx_tail[31:8]};
        if (rx_tail_ok) begin
          rx_crc_en = s_q.rx_kind == K_START || s_q.rx_kind == K_CONT;
          rx_xcrc_en = s_q.rx_kind == K_EXP;
        end else begin
          n.rx_tcnt = s_q.rx_tcnt + 3'h1;
        end
      end
    end else begin
      n.rx_cnt = 4'h0;
      if (s_q.rx_dv_q && s_q.rx_cnt == RX_DATA_IDX && s_q.rx_kind != K_NONE) begin
        n.rx_end = 1'b1;
        // an express frame never closes the preemptable reassembly
        if (rx_tail_ok && s_q.rx_tail == rx_chk) begin
          n.rx_active = s_q.rx_active && s_q.rx_kind == K_EXP;
        end else if (rx_tail_ok && s_q.rx_tail == (rx_fcs ^ MCRC_XOR)
                     && s_q.rx_kind != K_EXP) begin
          n.rx_cut = 1'b1;
        end else begin
          n.rx_discard = 1'b1;
          n.rx_active = s_q.rx_active && s_q.rx_kind == K_EXP;
        end
      end
    end
    // register slave; wstrb is not decoded
    if (s_q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp = wr_hit ? RESP_OKAY : RESP_DECERR;
      if (s_axi_awaddr == REG_CTRL) begin
        n.en = s_axi_wdata[CTRL_EN_BIT];
      end
      if (s_axi_awaddr == REG_VERIFY) begin
        n.verify = s_axi_wdata;
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_araddr == REG_CTRL) begin
      rd_v[CTRL_EN_BIT] = s_q.en;
      rd_v[CTRL_TXFC_LSB +: 2] = s_q.fcnt;
      rd_v[CTRL_RXFN_LSB +: 2] = s_q.rx_fnum;
    end else if (s_axi_araddr == REG_VERIFY) begin
      rd_v = s_q.verify;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp = rd_hit ? RESP_OKAY : RESP_DECERR;
      n.rdata = rd_v;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.en <= CTRL_EN_RST;
      s_q.verify <= VERIFY_RST;
    end else begin
      s_q <= n;
    end
  end

  assign tx_en = s_q.tx_en;
  assign txd = s_q.txd;
  assign rx_sof = s_q.rx_sof;
  assign rx_kind = s_q.rx_kind;
  assign rx_frame_num = s_q.rx_fnum;
  assign rx_end = s_q.rx_end;
  assign rx_cut = s_q.rx_cut;
  assign rx_discard = s_q.rx_discard;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  sequence s_mcrc_tail;
    (s_q.tx_st == TX_MCRC && tx_en) [*4] ##1 (s_q.tx_st == TX_IFG) ##1 !tx_en;
  endsequence

  chk_express_sfd: assert property (
    s_q.tx_st == TX_SFD && s_q.kind == K_EXP |=> tx_en && txd == SFD_EXP)
    else $error("express delimiter wrong");
  chk_start_smd: assert property (
    s_q.tx_st == TX_SFD && s_q.kind == K_START |=> txd == SMD_SYM[$past(s_q.fcnt)])
    else $error("frame count symbol wrong");
  chk_start_pre: assert property (
    s_q.tx_st == TX_PRE && s_q.cnt == PRE_LAST && s_q.kind != K_CONT |=> txd == PRE_BYTE)
    else $error("last preamble byte wrong");
  chk_cont_pre: assert property (
    s_q.tx_st == TX_PRE && s_q.cnt == PRE_LAST && s_q.kind == K_CONT
    |=> txd == FRAG_PRE[$past(s_q.fcnt)])
    else $error("continuation preamble wrong");
  chk_cont_smd: assert property (
    s_q.tx_st == TX_SFD && s_q.kind == K_CONT
    |=> txd == SMD_SYM[$past(s_q.gcnt)] ##1 s_q.gcnt == $past(s_q.gcnt, 2) + 2'h1)
    else $error("fragment count symbol wrong");
  chk_cut_mcrc: assert property (
    tx_cut |-> s_q.seg == SEG_LAST ##1 s_mcrc_tail)
    else $error("fragment crc sequence wrong");
  chk_cut_size: assert property (
    s_q.tx_st == TX_MCRC && s_q.cnt == 16'h0000
    |-> s_q.len >= MIN_CUT_LEN && s_q.len - s_q.done >= MIN_REMAIN && s_q.kind != K_EXP)
    else $error("cut on short remainder");
  chk_pass_data: assert property (
    pre_ready && pre_valid |=> tx_en && txd == $past(pre_data))
    else $error("preemptable byte altered");
  chk_full_end: assert property (
    pre_ready && pre_valid && pre_last |=> s_q.tx_st == TX_IFG ##1 !tx_en)
    else $error("finished frame got fragment crc");
  chk_decode_err: assert property (
    wr_go && !wr_hit |=> s_axi_bvalid && s_axi_bresp == RESP_DECERR)
    else $error("unmapped write not refused");
  chk_rx_sequence: assert property (
    rx_sfd_now && !rx_exp_hit && !rx_start_hit && rx_cont_hit && !rx_seq_ok
    |=> rx_sof && rx_discard && !s_q.rx_active)
    else $error("bad fragment order kept");
  chk_rx_express: assert property (
    rx_sfd_now && rx_exp_hit |=> rx_sof && rx_kind == K_EXP)
    else $error("express not classified");
endmodule

// ---- test/fpm_link_partner.sv ----
// remote link partner model: reflects the line back into the receive path
`timescale 1ns/10ps
module fpm_link_partner (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic tx_en,
  input wire logic [7:0] txd,
  input wire logic corrupt,
  output logic rx_dv,
  output logic [7:0] rxd
);
  // ==========================================================
  // one-cycle loopback
  logic [7:0] idx_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_dv <= 1'b0;
      rxd <= 8'h00;
      idx_q <= 8'h00;
    end else begin
      // preamble and delimiter relayed untouched
      rx_dv <= tx_en;
      idx_q <= tx_en ? idx_q + 8'h01 : 8'h00;
      if (tx_en) begin
        // first data byte damaged on command so the crc check must trip
        rxd <= (corrupt && idx_q == 8'h08) ? txd ^ 8'h01 : txd;
      end else begin
        // released line has no pull: show a changing level, not stale data
        rxd <= ~rxd;
      end
    end
  end
endmodule

// ---- test/fpm_top_bench.sv ----
// self-checking bench for the frame preemption merge block
`timescale 1ns/10ps
module fpm_top_bench;
  import fpm_pkg::*;
  // ==========================================================
  // signals
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic exp_valid = 1'b0, exp_last = 1'b0, pre_valid = 1'b0, pre_last = 1'b0;
  logic [7:0] exp_data = 8'h00, pre_data = 8'h00;
  logic [15:0] pre_len = 16'h0000;
  logic exp_ready, pre_ready, tx_en, rx_dv, rx_sof, rx_end, rx_cut, rx_discard;
  logic [7:0] txd, rxd;
  logic [1:0] rx_kind, rx_frame_num;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic corrupt = 1'b0;
  logic exp_tk = 1'b0, pre_tk = 1'b0;
  logic [7:0] eq[$], pq[$], txq[$], xq[$], ef[$], fr[$];
  logic [1:0] kq[$], xk[$];
  int trig[$];
  int pre_cnt = 0, cur_len = 0, ncut = 0, ndisc = 0, nend = 0, errors = 0, checked = 0, cyc = 0;
  logic [31:0] d;
  logic [1:0] r;

  always #50 mclk = ~mclk;

  fpm_top dut_u (
    .mclk, .rst_b, .exp_valid, .exp_data, .exp_last, .exp_ready,
    .pre_valid, .pre_data, .pre_last, .pre_len, .pre_ready, .tx_en, .txd,
    .rx_dv, .rxd, .rx_sof, .rx_kind, .rx_frame_num, .rx_end, .rx_cut, .rx_discard,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp
  );

  fpm_link_partner link_u (.mclk, .rst_b, .tx_en, .txd, .corrupt, .rx_dv, .rxd);

  // ==========================================================
  // monitors and timeout
  always @(posedge mclk) begin
    exp_tk <= exp_valid & exp_ready;
    pre_tk <= pre_valid & pre_ready;
    if (tx_en === 1'b1) txq.push_back(txd);
    if (rx_sof === 1'b1) kq.push_back(rx_kind);
    if (rx_cut === 1'b1) ncut++;
    if (rx_discard === 1'b1) ndisc++;
    if (rx_end === 1'b1) nend++;
    cyc++;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // byte sources, moved on the falling edge
  always @(negedge mclk) begin
    if (exp_tk) void'(eq.pop_front());
    if (pre_tk) begin
      void'(pq.pop_front());
      pre_cnt++;
    end
    // express traffic arrives while the preemptable frame is running
    if (trig.size() > 0 && pre_cnt == trig[0]) begin
      void'(trig.pop_front());
      eq = ef;
    end
    exp_valid = (eq.size() > 0);
    exp_data = exp_valid ? eq[0] : 8'h00;
    exp_last = (eq.size() == 1);
    pre_valid = (pq.size() > 0);
    pre_data = pre_valid ? pq[0] : 8'h00;
    pre_last = (pq.size() == 1);
    pre_len = 16'(cur_len);
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] crc_of(logic [7:0] b[$], int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h00_0000, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic mk(ref logic [7:0] f[$], input int len, input logic [7:0] s);
    logic [31:0] c;
    f = {};
    for (int i = 0; i < len - 4; i++) f.push_back(8'(i) ^ s);
    c = crc_of(f, len - 4);
    for (int i = 0; i < 4; i++) f.push_back(c[8*i +: 8]);
  endtask

  task automatic hdr(logic [7:0] lp, logic [7:0] sd, logic [1:0] k);
    repeat (6) xq.push_back(PRE_BYTE);
    xq.push_back(lp);
    xq.push_back(sd);
    xk.push_back(k);
  endtask

  // bytes a..b-1 of the frame, optionally closed by the modified crc
  task automatic part(int a, int b, bit mc);
    logic [31:0] c;
    for (int i = a; i < b; i++) xq.push_back(fr[i]);
    c = crc_of(fr, b) ^ MCRC_XOR;
    if (mc) for (int i = 0; i < 4; i++) xq.push_back(c[8*i +: 8]);
  endtask

  task automatic xexp();
    hdr(PRE_BYTE, SFD_EXP, K_EXP);
    foreach (ef[i]) xq.push_back(ef[i]);
  endtask

  task automatic settle();
    while (pq.size() + eq.size() > 0) @(posedge mclk);
    // covers the tail, the 12-cycle gap and the receive end pulse
    repeat (40) @(posedge mclk);
  endtask

  task automatic run(int len, logic [7:0] s, int t1, int t2);
    @(posedge mclk);
    mk(fr, len, s);
    pre_cnt = 0;
    cur_len = len;
    if (t1 > 0) trig.push_back(t1);
    if (t2 > 0) trig.push_back(t2);
    pq = fr;
    settle();
  endtask

  // full words only, at any address
  task automatic axw(logic [15:0] a, logic [31:0] v, output logic [1:0] rs);
    @(negedge mclk);
    s_axi_awaddr = a;
    s_axi_wdata = v;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    s_axi_bready = 1'b1;
    do @(posedge mclk); while ((s_axi_awready && s_axi_wready) !== 1'b1);
    @(negedge mclk);
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(negedge mclk);
    s_axi_bready = 1'b0;
  endtask

  task automatic axr(logic [15:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(negedge mclk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'b1;
    s_axi_rready = 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    @(negedge mclk);
    s_axi_arvalid = 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    @(negedge mclk);
    s_axi_rready = 1'b0;
  endtask

  // ==========================================================
  // comparisons and verdict
  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_byte(string nm, int i, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s %0d expected %h seen %h", nm, i, e, g);
    end
  endtask

  task automatic chk_line();
    cmp_word("line length", xq.size(), txq.size());
    foreach (xq[i]) cmp_byte("line byte", i, xq[i], i < txq.size() ? txq[i] : 8'hxx);
    cmp_word("rx frames", xk.size(), kq.size());
    foreach (xk[i]) cmp_byte("rx kind", i, {6'h00, xk[i]}, i < kq.size() ? {6'h00, kq[i]} : 8'hxx);
    xq = {};
    txq = {};
    xk = {};
    kq = {};
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mk(ef, 8, 8'hA5);
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    axr(REG_CTRL, d, r);
    cmp_word("ctrl reset", 32'h0000_0000, d);
    axr(REG_VERIFY, d, r);
    cmp_word("verify reset", VERIFY_RST, d);
    axw(REG_VERIFY, 32'h1234_5678, r);
    axw(16'h02B6, 32'hFFFF_FFFF, r);
    cmp_word("unaligned resp", RESP_DECERR, r);
    axr(REG_VERIFY, d, r);
    cmp_word("verify data", 32'h1234_5678, d);
    axr(16'h02B8, d, r);
    cmp_word("unmapped resp", RESP_DECERR, r);
    cmp_word("unmapped data", 32'h0000_0000, d);
    axw(REG_CTRL, 32'h0000_0001, r);
    cmp_word("ctrl resp", RESP_OKAY, r);
    run(130, 8'h11, 0, 0);
    hdr(PRE_BYTE, SMD_SYM[0], K_START);
    part(0, 130, 0);
    chk_line();
    // cut twice: 60 + 60 + 80 bytes
    run(200, 8'h22, 30, 90);
    hdr(PRE_BYTE, SMD_SYM[1], K_START);
    part(0, 60, 1);
    xexp();
    hdr(FRAG_PRE[1], SMD_SYM[0], K_CONT);
    part(60, 120, 1);
    xexp();
    hdr(FRAG_PRE[1], SMD_SYM[1], K_CONT);
    part(120, 200, 0);
    chk_line();
    cmp_word("rx cut pulses", 2, ncut);
    cmp_word("rx frame num", 32'h0000_0001, {30'h0, rx_frame_num});
    axr(REG_CTRL, d, r);
    cmp_word("ctrl counts", 32'h0000_0001 | (32'h0000_0002 << CTRL_TXFC_LSB)
             | (32'h0000_0001 << CTRL_RXFN_LSB), d);
    run(100, 8'h33, 30, 0);
    hdr(PRE_BYTE, SMD_SYM[2], K_START);
    part(0, 100, 0);
    xexp();
    chk_line();
    // express only after the 60 boundary; at the 120 boundary too little remains
    run(130, 8'h44, 70, 0);
    hdr(PRE_BYTE, SMD_SYM[3], K_START);
    part(0, 130, 0);
    xexp();
    chk_line();
    run(64, 8'h55, 0, 0);
    hdr(PRE_BYTE, SMD_SYM[0], K_START);
    part(0, 64, 0);
    chk_line();
    axw(REG_CTRL, 32'h0000_0000, r);
    run(200, 8'h66, 30, 0);
    hdr(PRE_BYTE, SFD_EXP, K_EXP);
    part(0, 200, 0);
    xexp();
    chk_line();
    cmp_word("rx discard pulses", 0, ndisc);
    @(negedge mclk);
    corrupt = 1'b1;
    @(posedge mclk);
    eq = ef;
    settle();
    xexp();
    chk_line();
    cmp_word("rx discard pulses", 1, ndisc);
    cmp_word("rx end pulses", 14, nend);
    print_verdict();
  end
endmodule
